// [rtl/stalm_defs.svh]
/*
 * register offsets, field positions, reset values and supply limits of the
 * status and alarm monitor.
 * assumes it is included by bare name, once per compile unit.
 */
`ifndef STALM_DEFS_SVH
`define STALM_DEFS_SVH

// ====================================================
// register byte offsets (lower byte of each word)
`define STALM_OFF_FLASH_CNT 7'h00
`define STALM_OFF_THR1 7'h26
`define STALM_OFF_THR2 7'h28
`define STALM_OFF_SMPL1 7'h2A
`define STALM_OFF_SMPL2 7'h2C
`define STALM_OFF_CTRL 7'h2E
`define STALM_OFF_STATUS 7'h3C

// ====================================================
// reset values
`define STALM_RST_WORD 16'h0000

// ====================================================
// threshold fields
`define STALM_THR_DIR 15
`define STALM_THR_MSB 13

// ====================================================
// alarm control fields
`define STALM_CTRL_SRC2_MSB 15
`define STALM_CTRL_SRC2_LSB 12
`define STALM_CTRL_SRC1_MSB 11
`define STALM_CTRL_SRC1_LSB 8
`define STALM_CTRL_ROC2 7
`define STALM_CTRL_ROC1 6
`define STALM_CTRL_FILT 4
`define STALM_CTRL_PIN_EN 2
`define STALM_CTRL_POL 1
`define STALM_CTRL_LINE 0

// ====================================================
// status bit positions
`define STALM_ST_DIAG_LSB 10
`define STALM_ST_ALM2 9
`define STALM_ST_ALM1 8
`define STALM_ST_SELFTEST 5
`define STALM_ST_OVR 4
`define STALM_ST_COMM 3
`define STALM_ST_CTRLUPD 2
`define STALM_ST_SUP_HI 1
`define STALM_ST_SUP_LO 0

// ====================================================
// supply limits in millivolts, compared against the supply channel
`define STALM_SUP_HI_MV 5250
`define STALM_SUP_LO_MV 4750

`endif

// [rtl/stalm_pkg.sv]
/*
 * types of the status and alarm monitor.
 * assumes nothing beyond a systemverilog compiler.
 */
package stalm_pkg;
	// alarm source selection codes
	typedef enum logic [3:0] {
		STALM_SRC_OFF = 4'h0,
		STALM_SRC_SUPPLY = 4'h1,
		STALM_SRC_GYRO_X = 4'h2,
		STALM_SRC_GYRO_Y = 4'h3,
		STALM_SRC_GYRO_Z = 4'h4,
		STALM_SRC_ACC_X = 4'h5,
		STALM_SRC_ACC_Y = 4'h6,
		STALM_SRC_ACC_Z = 4'h7,
		STALM_SRC_TEMP_X = 4'h8,
		STALM_SRC_TEMP_Y = 4'h9,
		STALM_SRC_TEMP_Z = 4'hA,
		STALM_SRC_AUX = 4'hB
	} stalm_src_t;
endpackage

// [rtl/stalm_monitor.sv]
/*
 * status word, flash write counter and two programmable alarms.
 * assumes a register port (byte address, word strobes) from the serial
 * front end on clk, channel samples on clk with a one-cycle update pulse,
 * and pin conflicts beyond data-ready resolved by the pin muxing here.
 */
//
// Function
// - count every flash write, read only
// - counter wraps to zero past maximum
// - supply and overrange flags self clear
// - other error flags latch until read
// - status read clears whole word
// - persisting errors reset at next update
// - bits 15:10 per sensor diagnostic failures
// - bit 9 alarm two, bit 8 one
// - bits 5..2 self-test, overrange, comm, control
// - bit1 supply high, bit0 supply low
// - two independent alarms raise events
// - threshold bit15 direction, bits13:0 value
// - rate mode averages sample deltas
// - alarm two source field bits 15:12
// - alarm one source same encoding, 11:8
// - bits 7/6 select rate mode
// - filter bit selects filtered source
// - pin enable, polarity, line select bits
// - data-ready beats alarm beats gpio
// - self-test flag plus per-sensor flags
`timescale 1ns/1ps
`default_nettype none
`include "stalm_defs.svh"

module stalm_monitor #(
	parameter int CNT_W = 15
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// update cycle and channel data, 14-bit samples
	input wire logic update_tick,
	input wire logic [13:0] chan_raw [12],
	input wire logic [13:0] chan_filt [12],
	// error conditions
	input wire logic flash_write,
	input wire logic [5:0] sensor_diag_fail,
	input wire logic selftest_fail,
	input wire logic overrange,
	input wire logic comm_fail,
	input wire logic ctrl_update_fail,
	// pin arbitration
	input wire logic drdy_en,
	input wire logic drdy_line,
	input wire logic drdy_level,
	input wire logic [1:0] gpio_oe,
	input wire logic [1:0] gpio_out,
	// digital pins
	output logic digital_pin_one_o,
	output logic digital_pin_one_oe,
	output logic digital_pin_two_o,
	output logic digital_pin_two_oe
);
	// ====================================================
	// registers
	logic [CNT_W-1:0] flash_cnt_ff; // write counter
	logic [15:0] thr_ff [2]; // thresholds
	logic [15:0] smpl_ff [2]; // sample counts
	logic [15:0] ctrl_ff; // alarm control
	logic [15:0] status_ff; // error flags
	logic [15:0] rdata_ff; // read data
	logic [1:0] alarm_ff; // alarm active
	logic [13:0] prev_ff [2]; // last sample
	logic [29:0] acc_ff [2]; // delta sum
	logic [15:0] nacc_ff [2]; // deltas summed
	logic [15:0] nxt_status;
	logic st_read;

	// word address match, either byte of the word
	function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
		hit = (a[6:1] == off[6:1]);
	endfunction

	assign st_read = reg_rd && hit(reg_addr, `STALM_OFF_STATUS);

	// ====================================================
	// flash write counter, wraps by natural overflow
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flash_cnt_ff <= '0;
		end else if (flash_write) begin
			flash_cnt_ff <= flash_cnt_ff + 1'b1;
		end
	end

	// ====================================================
	// writable configuration
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			thr_ff[0] <= `STALM_RST_WORD;
			thr_ff[1] <= `STALM_RST_WORD;
			smpl_ff[0] <= `STALM_RST_WORD;
			smpl_ff[1] <= `STALM_RST_WORD;
			ctrl_ff <= `STALM_RST_WORD;
		end else if (reg_wr) begin
			if (hit(reg_addr, `STALM_OFF_THR1)) thr_ff[0] <= reg_wdata;
			if (hit(reg_addr, `STALM_OFF_THR2)) thr_ff[1] <= reg_wdata;
			if (hit(reg_addr, `STALM_OFF_SMPL1)) smpl_ff[0] <= reg_wdata;
			if (hit(reg_addr, `STALM_OFF_SMPL2)) smpl_ff[1] <= reg_wdata;
			if (hit(reg_addr, `STALM_OFF_CTRL)) ctrl_ff <= reg_wdata;
		end
	end

	// ====================================================
	// alarm engines
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_alm
			logic [3:0] src; // source code
			logic rate_of_change_mode; // rate mode
			logic [13:0] smp; // selected sample
			logic signed [14:0] delta; // prev minus new
			logic signed [29:0] sum; // sum incl. new delta
			logic [15:0] n; // effective count
			logic signed [29:0] yc; // comparison factor
			logic signed [14:0] mc; // threshold
			logic hitc; // condition met
			// alarm two uses 15:12, alarm one 11:8
			assign src = (g == 1) ? ctrl_ff[`STALM_CTRL_SRC2_MSB:`STALM_CTRL_SRC2_LSB]
				: ctrl_ff[`STALM_CTRL_SRC1_MSB:`STALM_CTRL_SRC1_LSB];
			assign rate_of_change_mode = ctrl_ff[(g == 1) ? `STALM_CTRL_ROC2 : `STALM_CTRL_ROC1];
			// supply is channel code 1, up to aux at 11
			always_comb begin
				if (src == stalm_pkg::STALM_SRC_OFF || src > stalm_pkg::STALM_SRC_AUX) begin
					smp = '0;
				end else if (ctrl_ff[`STALM_CTRL_FILT]) begin
					smp = chan_filt[src - 4'h1];
				end else begin
					smp = chan_raw[src - 4'h1];
				end
			end
			assign delta = $signed({1'b0, prev_ff[g]}) - $signed({1'b0, smp});
			assign sum = acc_ff[g] + 30'(delta);
			assign n = (smpl_ff[g] == 16'h0000) ? 16'h0001 : smpl_ff[g];
			assign yc = rate_of_change_mode ? sum / $signed({14'h0000, n}) : $signed({16'h0000, smp});
			assign mc = $signed({1'b0, thr_ff[g][`STALM_THR_MSB:0]});
			// threshold bit 15 picks greater or less than
			assign hitc = thr_ff[g][`STALM_THR_DIR] ? (yc > 30'(mc)) : (yc < 30'(mc));

			// averaging window and alarm decision, per update cycle
			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					prev_ff[g] <= '0;
					acc_ff[g] <= '0;
					nacc_ff[g] <= '0;
					alarm_ff[g] <= 1'b0;
				end else if (update_tick) begin
					prev_ff[g] <= smp;
					if (src == stalm_pkg::STALM_SRC_OFF) begin
						alarm_ff[g] <= 1'b0; // disabled alarm is quiet
						acc_ff[g] <= '0;
						nacc_ff[g] <= '0;
					end else if (!rate_of_change_mode) begin
						alarm_ff[g] <= hitc;
					end else if (nacc_ff[g] + 16'h0001 >= n) begin
						// window complete: judge the average, start over
						alarm_ff[g] <= hitc;
						acc_ff[g] <= '0;
						nacc_ff[g] <= '0;
					end else begin
						acc_ff[g] <= sum;
						nacc_ff[g] <= nacc_ff[g] + 16'h0001;
					end
				end
			end
		end
	endgenerate

	// ====================================================
	// status word: conditions enter only at update cycles, so a cleared
	// persisting error comes back one update later rather than at once
	always_comb begin
		nxt_status = status_ff;
		if (st_read) begin
			nxt_status = `STALM_RST_WORD;
		end
		if (update_tick) begin
			// self-clearing bits follow the condition
			nxt_status[`STALM_ST_OVR] = overrange;
			nxt_status[`STALM_ST_SUP_HI] = (chan_raw[0] > 14'(`STALM_SUP_HI_MV));
			nxt_status[`STALM_ST_SUP_LO] = (chan_raw[0] < 14'(`STALM_SUP_LO_MV));
			// sticky bits: set wins over a simultaneous read clear
			nxt_status[15:`STALM_ST_DIAG_LSB] = nxt_status[15:`STALM_ST_DIAG_LSB]
				| sensor_diag_fail;
			nxt_status[`STALM_ST_ALM2] = nxt_status[`STALM_ST_ALM2] | alarm_ff[1];
			nxt_status[`STALM_ST_ALM1] = nxt_status[`STALM_ST_ALM1] | alarm_ff[0];
			nxt_status[`STALM_ST_SELFTEST] = nxt_status[`STALM_ST_SELFTEST] | selftest_fail;
			nxt_status[`STALM_ST_COMM] = nxt_status[`STALM_ST_COMM] | comm_fail;
			nxt_status[`STALM_ST_CTRLUPD] = nxt_status[`STALM_ST_CTRLUPD] | ctrl_update_fail;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_ff <= `STALM_RST_WORD;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// ====================================================
	// read data, registered one cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr[6:1])
				6'(`STALM_OFF_FLASH_CNT >> 1): rdata_ff <= 16'(flash_cnt_ff);
				6'(`STALM_OFF_THR1 >> 1): rdata_ff <= thr_ff[0];
				6'(`STALM_OFF_THR2 >> 1): rdata_ff <= thr_ff[1];
				6'(`STALM_OFF_SMPL1 >> 1): rdata_ff <= smpl_ff[0];
				6'(`STALM_OFF_SMPL2 >> 1): rdata_ff <= smpl_ff[1];
				6'(`STALM_OFF_CTRL >> 1): rdata_ff <= ctrl_ff;
				6'(`STALM_OFF_STATUS >> 1): rdata_ff <= status_ff;
				default: rdata_ff <= '0; // unmapped reads zero
			endcase
		end
	end
	assign reg_rdata = rdata_ff;

	// ====================================================
	// pin arbitration: data-ready, then alarm, then gpio
	logic alm_any;
	logic alm_lvl;
	logic alm_use [2];
	assign alm_any = |alarm_ff;
	// polarity 1 drives high while active
	assign alm_lvl = ctrl_ff[`STALM_CTRL_POL] ? alm_any : ~alm_any;
	always_comb begin
		alm_use[0] = ctrl_ff[`STALM_CTRL_PIN_EN] && !ctrl_ff[`STALM_CTRL_LINE];
		alm_use[1] = ctrl_ff[`STALM_CTRL_PIN_EN] && ctrl_ff[`STALM_CTRL_LINE];
		alm_use[0] = alm_use[0] && !(drdy_en && !drdy_line);
		alm_use[1] = alm_use[1] && !(drdy_en && drdy_line);
	end
	assign digital_pin_one_oe = (drdy_en && !drdy_line) || alm_use[0] || gpio_oe[0];
	assign digital_pin_one_o = (drdy_en && !drdy_line) ? drdy_level
		: alm_use[0] ? alm_lvl : gpio_out[0];
	assign digital_pin_two_oe = (drdy_en && drdy_line) || alm_use[1] || gpio_oe[1];
	assign digital_pin_two_o = (drdy_en && drdy_line) ? drdy_level
		: alm_use[1] ? alm_lvl : gpio_out[1];

	// ====================================================
	// checks
	a_status_read_clr: assert property (@(posedge clk) disable iff (!nrst)
		st_read && !update_tick |=> status_ff == `STALM_RST_WORD) else $error("status not cleared by read");
	a_flash_cnt_inc: assert property (@(posedge clk) disable iff (!nrst)
		flash_write |=> flash_cnt_ff == $past(flash_cnt_ff) + 1'b1) else $error("flash count wrong");
	a_sticky_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
		status_ff[`STALM_ST_COMM] && !st_read |=> status_ff[`STALM_ST_COMM]) else $error("comm flag lost");
	a_error_reasserts: assert property (@(posedge clk) disable iff (!nrst)
		update_tick && comm_fail |=> status_ff[`STALM_ST_COMM]) else $error("comm flag not set");
	a_overrange_follows: assert property (@(posedge clk) disable iff (!nrst)
		update_tick && !overrange |=> !status_ff[`STALM_ST_OVR]) else $error("overrange stuck");
	a_alarm_status_bit: assert property (@(posedge clk) disable iff (!nrst)
		update_tick && alarm_ff[1] |=> status_ff[`STALM_ST_ALM2]) else $error("alarm two not flagged");
	a_drdy_wins_pin: assert property (@(posedge clk) disable iff (!nrst)
		drdy_en && !drdy_line |-> digital_pin_one_o == drdy_level) else $error("data-ready lost pin");
	a_alarm_off_quiet: assert property (@(posedge clk) disable iff (!nrst)
		update_tick && g_alm[0].src == stalm_pkg::STALM_SRC_OFF |=> !alarm_ff[0]) else $error("disabled alarm");
endmodule
`default_nettype wire

// [bench/stalm_host.sv]
/*
 * host model: drives the register port the way the serial front end does.
 * assumes the bench clock; strobes change on falling edges only.
 */
`timescale 1ns/1ps
`default_nettype none
module stalm_host (
	// clock
	input wire logic clk,
	// register port
	output logic [6:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata
);
	// ====================================================
	// idle levels
	initial begin
		reg_addr = 7'h7F;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 16'h0000;
	end
	// one-cycle write strobe; a released data bus shows the inverse value
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(negedge clk);
		reg_wr = 1'h0;
		reg_wdata = ~d;
	endtask
	// one-cycle read strobe; data is registered, so taken a cycle later
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'h1;
		@(negedge clk);
		reg_rd = 1'h0;
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// [bench/status_alarm_monitor_bench.sv]
/*
 * self-checking bench of the status and alarm monitor.
 * assumes stalm_defs.svh on the include path and the host model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
`include "stalm_defs.svh"
module status_alarm_monitor_bench;
	// ====================================================
	// signals
	logic clk, nrst, rd, wr, tick, fw, st, ovr, com, cuf, de, dl, dv;
	logic p1, p1e, p2, p2e;
	logic [6:0] addr;
	logic [15:0] wd, rdat, v;
	logic [13:0] raw [12];
	logic [13:0] filt [12];
	logic [5:0] diag;
	int err_total, num_checks;
	// short counter width keeps the wrap quick
	stalm_monitor #(.CNT_W(4)) dut_u (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
		.reg_wdata(wd), .reg_rdata(rdat), .update_tick(tick), .chan_raw(raw), .chan_filt(filt),
		.flash_write(fw), .sensor_diag_fail(diag), .selftest_fail(st), .overrange(ovr), .comm_fail(com),
		.ctrl_update_fail(cuf), .drdy_en(de), .drdy_line(dl), .drdy_level(dv), .gpio_oe(2'h0),
		.gpio_out(2'h0), .digital_pin_one_o(p1), .digital_pin_one_oe(p1e), .digital_pin_two_o(p2),
		.digital_pin_two_oe(p2e));
	stalm_host host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat));
	// ====================================================
	// clock, 50 ns period
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one pulse on an input, launched on a falling edge
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'h1;
		@(negedge clk);
		s = 1'h0;
	endtask
	// read a word and compare it
	task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
		host_u.rd(a, v);
		chk(v, exp);
	endtask
	// ====================================================
	// reset values, read back, read-only and unmapped places
	task automatic t_regs;
		logic [6:0] rw [5];
		rw = '{`STALM_OFF_THR1, `STALM_OFF_THR2, `STALM_OFF_SMPL1, `STALM_OFF_SMPL2, `STALM_OFF_CTRL};
		foreach (rw[i]) rchk(rw[i], 16'h0000);
		rchk(`STALM_OFF_STATUS, 16'h0000);
		foreach (rw[i]) host_u.wr(rw[i], 16'hA5C3 ^ 16'(i));
		foreach (rw[i]) rchk(rw[i], 16'hA5C3 ^ 16'(i));
		foreach (rw[i]) host_u.wr(rw[i], 16'h0000);
		host_u.wr(`STALM_OFF_STATUS, 16'hFFFF);
		host_u.wr(`STALM_OFF_FLASH_CNT, 16'h0007);
		host_u.wr(7'h10, 16'h1234);
		rchk(`STALM_OFF_STATUS, 16'h0000);
		rchk(`STALM_OFF_FLASH_CNT, 16'h0000);
		rchk(7'h11, 16'h0000);
	endtask
	// counter counts to its top value, then wraps through zero
	task automatic t_flash;
		repeat (15) pulse(fw);
		rchk(`STALM_OFF_FLASH_CNT, 16'h000F);
		repeat (2) pulse(fw);
		rchk(`STALM_OFF_FLASH_CNT, 16'h0001);
	endtask
	// latched versus self-clearing flags, clear on read, re-set on update
	task automatic t_status;
		{com, cuf, ovr, st} = 4'hF;
		diag = 6'h2A;
		raw[0] = 14'd5300;
		pulse(tick);
		{com, cuf, ovr} = 3'h0;
		diag = 6'h00;
		raw[0] = 14'd5000;
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'hA82C);
		rchk(`STALM_OFF_STATUS, 16'h0000);
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0020);
		st = 1'h0;
		ovr = 1'h1;
		raw[0] = 14'd4700;
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0011);
		ovr = 1'h0;
		raw[0] = 14'd5000;
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0000);
	endtask
	// two static alarms, status bits and pin drive
	task automatic t_alarm;
		host_u.wr(`STALM_OFF_THR1, 16'h8064);
		host_u.wr(`STALM_OFF_THR2, 16'h0032);
		host_u.wr(`STALM_OFF_CTRL, 16'h5206);
		raw[1] = 14'd200;
		raw[4] = 14'd10;
		repeat (2) pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0300);
		chk({14'h0, p1e, p1}, 16'h0003);
		host_u.wr(`STALM_OFF_CTRL, 16'h5204);
		chk({14'h0, p1e, p1}, 16'h0002);
		host_u.wr(`STALM_OFF_CTRL, 16'h5207);
		chk({14'h0, p2e, p2}, 16'h0003);
		{de, dl, dv} = 3'h6;
		@(negedge clk);
		chk({14'h0, p2e, p2}, 16'h0002);
		de = 1'h0;
		raw[1] = 14'd50;
		repeat (2) pulse(tick);
		// the first tick still sees alarm one active, and its flag is sticky
		rchk(`STALM_OFF_STATUS, 16'h0300);
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0200);
		// rate mode on alarm one, count zero acts as one sample
		host_u.wr(`STALM_OFF_THR1, 16'h8005);
		host_u.wr(`STALM_OFF_CTRL, 16'h0240);
		pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0200);
		raw[1] = 14'd40;
		repeat (2) pulse(tick);
		rchk(`STALM_OFF_STATUS, 16'h0100);
	endtask
	// ====================================================
	// verdict
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// watchdog: the whole run needs well under 200 us
	initial begin
		#500000;
		err_total++;
		finish_test();
	end
	// main sequence
	initial begin
		{nrst, tick, fw, st, ovr, com, cuf, de, dl, dv} = 10'h0;
		diag = 6'h00;
		foreach (raw[i]) raw[i] = 14'd5000;
		foreach (filt[i]) filt[i] = 14'h0000;
		repeat (10) @(negedge clk);
		nrst = 1'h1;
		t_regs();
		t_flash();
		t_status();
		t_alarm();
		finish_test();
	end
endmodule
`default_nettype wire
